// [hw/mfch_cfg.svh]
// constants of the monitor/feature channel handler
// assumes one serial port of 32 eight-bit slots per frame
`ifndef MFCH_CFG_SVH
`define MFCH_CFG_SVH
`define MFCH_IDLE_BYTE 8'hff
`define MFCH_FRAME_LAST 8'hff
`define MFCH_MODE_BIDIR 2'h3
`define MFCH_BIDIR_OFFSET 5'h04
`define MFCH_MON_SLOT 2'h2
`define MFCH_FLAG_SLOT 2'h3
`define MFCH_CODE_IDLE 2'h0
`define MFCH_CODE_TX 2'h1
`define MFCH_CODE_TXRX 2'h2
`define MFCH_CODE_TX3 2'h3
`define MFCH_TC_BCAST 2'h1
`define MFCH_EXP_0 5'h01
`define MFCH_EXP_1 5'h02
`define MFCH_EXP_2 5'h08
`define MFCH_EXP_3 5'h10
`define MFCH_BUF_DEPTH 16
`endif

// [hw/mfch_handler.sv]
// monitor/feature channel handler: buffer, transfer engine, serial slot logic
// assumes link pins are timed by link_clock, frame_sync high on bit 0 of a frame
`timescale 1ns/100ps
`default_nettype none
`include "mfch_cfg.svh"
module mfch_handler #(
   parameter int BUF_DEPTH = `MFCH_BUF_DEPTH
) (
   // system
   input wire logic clock,
   input wire logic rstn,
   // host control and configuration
   input wire mfch_pkg::mfch_cmd_s cmd,
   input wire logic protocol_select_bit,
   input wire logic [1:0] interface_mode,
   input wire logic [7:0] target_slot_register,
   input wire logic [7:0] mf_slot_map,
   // host buffer access
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   input wire logic rd_req,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // host status
   output logic xfer_busy,
   output logic buf_empty,
   output logic buf_read_mode,
   output logic [7:0] active_channel_register,
   output logic active_channel_interrupt,
   // serial link
   input wire logic link_clock,
   input wire logic frame_sync,
   output logic downstream_line,
   input wire logic upstream_line,
   input wire logic port_line_in,
   output logic port_line_out,
   output logic port_line_oe
);
   import mfch_pkg::*;
   localparam int AW = $clog2(BUF_DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(BUF_DEPTH);

   generate
      if (BUF_DEPTH < 2 || BUF_DEPTH > 16 || (1 << AW) != BUF_DEPTH) begin : g_bad
         $error("mfch_handler: BUF_DEPTH must be a power of two from 2 to 16");
      end
   endgenerate

   // host domain state
   logic [7:0] mem [BUF_DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   mfch_state_e state, next_state;
   mfch_dn_s dn, next_dn;
   logic [1:0] code_q, next_code_q;
   logic [4:0] rx_exp, next_rx_exp, rx_cnt, next_rx_cnt;
   logic prev_mx, next_prev_mx;
   logic [7:0] last_byte, next_last_byte;
   logic read_mode, next_read_mode;
   logic search_on, next_search_on;
   logic [5:0] active_addr, next_active_addr;
   logic next_irq;
   logic [7:0] next_rd_data;
   logic next_rd_valid, next_busy;
   logic push;
   logic [7:0] push_data;
   logic [7:0] pop_data;
   // crossing of the frame event
   logic tog_meta, tog_sync, tog_seen;
   logic ev;
   mfch_up_s up_hold, next_up_hold;
   // link domain state
   logic lrst_meta, lrst_n;
   logic [7:0] cnt, next_cnt;
   logic [7:0] sh_in, next_sh_in;
   mfch_dn_s dnl, next_dnl;
   mfch_up_s work, next_work;
   logic tog, next_tog;
   logic next_dl, next_pl, next_oe;

   assign pop_data = mem[rd_ptr];
   assign ev = tog_sync ^ tog_seen;
   assign active_channel_register = {1'b0, search_on, active_addr};

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      next_state = state;
      next_dn = dn;
      next_code_q = code_q;
      next_rx_exp = rx_exp;
      next_rx_cnt = rx_cnt;
      next_prev_mx = prev_mx;
      next_last_byte = last_byte;
      next_read_mode = read_mode;
      next_search_on = search_on;
      next_active_addr = active_addr;
      next_irq = 1'b0;
      next_rd_data = rd_data;
      next_rd_valid = 1'b0;
      next_busy = xfer_busy;
      push = 1'b0;
      push_data = wr_data;
      // quasi-static settings follow the inputs
      next_dn.mode3 = (interface_mode == `MFCH_MODE_BIDIR);
      next_dn.slot_map = mf_slot_map;
      // host buffer access, only while no transfer runs
      if (state == ST_IDLE && !read_mode && wr_valid && count < DEPTH_C) begin
         push = 1'b1;
      end
      if (state == ST_IDLE && read_mode && rd_req && count != '0) begin
         next_rd_data = pop_data;
         next_rd_valid = 1'b1;
         next_rd_ptr = rd_ptr + 1'b1;
         next_count = count - 1'b1;
      end
      case (state)
         ST_IDLE: begin
            // a start needs a marked channel, or broadcast
            if (cmd.start && cmd.code != `MFCH_CODE_IDLE && (mf_slot_map[target_slot_register[4:2]]
                || (cmd.code == `MFCH_CODE_TX && target_slot_register[7:6] == `MFCH_TC_BCAST))) begin
               next_state = ST_TX;
               next_busy = 1'b1;
               next_read_mode = 1'b0;
               next_code_q = cmd.code;
               next_dn.addr = {target_slot_register[5:1], 1'b0};
               next_dn.bcast = (cmd.code == `MFCH_CODE_TX)
                  && (target_slot_register[7:6] == `MFCH_TC_BCAST);
               case (target_slot_register[7:6])
                  2'h0: next_rx_exp = `MFCH_EXP_0;
                  2'h1: next_rx_exp = `MFCH_EXP_1;
                  2'h2: next_rx_exp = `MFCH_EXP_2;
                  default: next_rx_exp = `MFCH_EXP_3;
               endcase
               next_rx_cnt = '0;
               next_prev_mx = 1'b0;
               next_dn.mr_act = 1'b0;
               if (count != '0) begin
                  next_dn.data = pop_data;
                  next_dn.drive = 1'b1;
                  next_dn.mx_act = protocol_select_bit;
                  next_rd_ptr = rd_ptr + 1'b1;
                  next_count = count - 1'b1;
               end
            end
         end
         ST_TX: begin
            if (ev) begin
               // handshaked: advance only after the receive flag or while no byte is driven; else one frame per byte
               if (!protocol_select_bit || up_hold.mr_act || !dn.drive) begin
                  if (count != '0) begin
                     next_dn.data = pop_data;
                     next_dn.drive = 1'b1;
                     next_dn.mx_act = protocol_select_bit;
                     next_rd_ptr = rd_ptr + 1'b1;
                     next_count = count - 1'b1;
                  end else if (protocol_select_bit && code_q == `MFCH_CODE_TX3) begin
                     next_dn.mx_act = dn.mx_act; // continuous: last byte keeps going
                  end else begin
                     next_dn.drive = 1'b0;
                     next_dn.mx_act = 1'b0;
                     next_dn.bcast = 1'b0;
                     // receive starts only once transmit is done
                     if (code_q == `MFCH_CODE_TXRX || (!protocol_select_bit
                         && code_q == `MFCH_CODE_TX3)) begin
                        next_state = ST_RX;
                        next_read_mode = 1'b1;
                     end else begin
                        next_state = ST_IDLE;
                        next_busy = 1'b0;
                     end
                  end
               end
            end
         end
         ST_RX: begin
            if (ev) begin
               push_data = up_hold.data;
               if (protocol_select_bit) begin
                  next_prev_mx = up_hold.mx_act;
                  if (up_hold.mx_act && (!prev_mx || up_hold.data != last_byte)
                      && count < DEPTH_C) begin
                     push = 1'b1;
                     next_dn.mr_act = 1'b1;
                     next_last_byte = up_hold.data;
                     next_rx_cnt = rx_cnt + 1'b1;
                  end
                  if ((!up_hold.mx_act && rx_cnt != '0) || count == DEPTH_C) begin
                     next_state = ST_IDLE;
                     next_busy = 1'b0;
                     next_dn.mr_act = 1'b0;
                  end
               end else begin
                  // only non-idle bytes count as answers
                  if (up_hold.data != `MFCH_IDLE_BYTE && count < DEPTH_C) begin
                     push = 1'b1;
                     next_rx_cnt = rx_cnt + 1'b1;
                     if (5'(rx_cnt + 5'h01) == rx_exp) begin
                        next_state = ST_IDLE;
                        next_busy = 1'b0;
                     end
                  end
                  if (count == DEPTH_C) begin
                     next_state = ST_IDLE;
                     next_busy = 1'b0;
                  end
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (push) begin
         next_wr_ptr = wr_ptr + 1'b1;
         next_count = next_count + 1'b1;
      end
      if (cmd.buf_reset) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
         next_state = ST_IDLE;
         next_busy = 1'b0;
         next_read_mode = 1'b0;
         next_dn.drive = 1'b0;
         next_dn.bcast = 1'b0;
         next_dn.mx_act = 1'b0;
         next_dn.mr_act = 1'b0;
      end
      // search is independent of transfers and of buffer reset
      if (cmd.search && protocol_select_bit) begin
         next_search_on = 1'b1;
      end else if (search_on && ev && up_hold.found) begin
         next_search_on = 1'b0;
         next_active_addr = up_hold.found_addr;
         next_irq = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= push_data;
      end
      tog_meta <= tog;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         state <= ST_IDLE;
         dn <= '0;
         code_q <= `MFCH_CODE_IDLE;
         rx_exp <= `MFCH_EXP_0;
         rx_cnt <= '0;
         prev_mx <= 1'b0;
         last_byte <= `MFCH_IDLE_BYTE;
         read_mode <= 1'b0;
         search_on <= 1'b0;
         active_addr <= '0;
         active_channel_interrupt <= 1'b0;
         rd_data <= '0;
         rd_valid <= 1'b0;
         xfer_busy <= 1'b0;
         buf_empty <= 1'b1;
         buf_read_mode <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         state <= next_state;
         dn <= next_dn;
         code_q <= next_code_q;
         rx_exp <= next_rx_exp;
         rx_cnt <= next_rx_cnt;
         prev_mx <= next_prev_mx;
         last_byte <= next_last_byte;
         read_mode <= next_read_mode;
         search_on <= next_search_on;
         active_addr <= next_active_addr;
         active_channel_interrupt <= next_irq;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
         xfer_busy <= next_busy;
         buf_empty <= (next_count == '0);
         buf_read_mode <= next_read_mode;
      end
   end

   // link domain: serial slot logic
   always_comb begin
      logic [7:0] cur;
      logic [7:0] pos;
      logic [7:0] fbyte;
      logic [4:0] txs;
      logic [4:0] rxs;
      logic rx_in;
      logic is_tx;
      logic is_flag;
      logic obit;
      cur = frame_sync ? 8'h00 : cnt;
      pos = 8'(cur + 8'h01);
      txs = dnl.addr[4:0];
      rxs = dnl.mode3 ? 5'(txs + `MFCH_BIDIR_OFFSET) : txs;
      rx_in = dnl.mode3 ? port_line_in : upstream_line;
      fbyte = {sh_in[6:0], rx_in};
      next_cnt = pos;
      next_sh_in = fbyte;
      next_work = work;
      next_tog = tog;
      next_up_hold = up_hold;
      next_dnl = dnl;
      if (cur[2:0] == 3'h7) begin
         if (cur[7:3] == rxs) begin
            next_work.data = fbyte;
         end
         if (cur[7:3] == 5'(rxs + 5'h01)) begin
            next_work.mr_act = ~fbyte[1];
            next_work.mx_act = ~fbyte[0];
         end
         // first marked channel with its transmit flag low wins
         if (cur[4:3] == `MFCH_FLAG_SLOT && dnl.slot_map[cur[7:5]] && !fbyte[0]
             && !work.found) begin
            next_work.found = 1'b1;
            next_work.found_addr = {1'b0, cur[7:5], `MFCH_MON_SLOT};
         end
      end
      if (cur == `MFCH_FRAME_LAST) begin
         next_up_hold = next_work;
         next_work = '0;
         next_work.data = `MFCH_IDLE_BYTE;
         next_tog = ~tog;
         next_dnl = dn;
      end
      is_tx = dnl.drive && ((pos[7:3] == txs) || (dnl.bcast
         && pos[4:3] == `MFCH_MON_SLOT && dnl.slot_map[pos[7:5]])) && dnl.slot_map[pos[7:5]];
      is_flag = (dnl.mx_act || dnl.mr_act) && pos[7:3] == 5'(txs + 5'h01);
      fbyte = {6'h3f, ~dnl.mr_act, ~dnl.mx_act};
      obit = 1'b1;
      if (is_tx) begin
         obit = dnl.data[3'h7 - pos[2:0]];
      end else if (is_flag) begin
         obit = fbyte[3'h7 - pos[2:0]];
      end
      next_dl = dnl.mode3 ? 1'b1 : obit;
      next_pl = obit;
      // drive only the down half of each eight-slot group, so the answer four slots later is free
      next_oe = dnl.mode3 && (is_tx || is_flag) && !pos[5];
   end

   always_ff @(posedge link_clock) begin
      lrst_meta <= rstn;
      lrst_n <= lrst_meta;
      if (!lrst_n) begin
         cnt <= '0;
         sh_in <= `MFCH_IDLE_BYTE;
         dnl <= '0;
         work <= '0;
         up_hold <= '0;
         tog <= 1'b0;
         downstream_line <= 1'b1;
         port_line_out <= 1'b1;
         port_line_oe <= 1'b0;
      end else begin
         cnt <= next_cnt;
         sh_in <= next_sh_in;
         dnl <= next_dnl;
         work <= next_work;
         up_hold <= next_up_hold;
         tog <= next_tog;
         downstream_line <= next_dl;
         port_line_out <= next_pl;
         port_line_oe <= next_oe;
      end
   end
endmodule : mfch_handler
`default_nettype wire

// [hw/mfch_pkg.sv]
// types of the monitor/feature channel handler
// assumes mfch_cfg.svh for all numeric constants
package mfch_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TX = 2'b01,
      ST_RX = 2'b10
   } mfch_state_e;
   // one frame's findings, link side to host side
   typedef struct packed {
      logic [7:0] data;
      logic mr_act;
      logic mx_act;
      logic found;
      logic [5:0] found_addr;
   } mfch_up_s;
   // what the link sends next frame, host side to link side
   typedef struct packed {
      logic [7:0] data;
      logic drive;
      logic bcast;
      logic mx_act;
      logic mr_act;
      logic mode3;
      logic [5:0] addr;
      logic [7:0] slot_map;
   } mfch_dn_s;
   typedef struct packed {
      logic [1:0] code;
      logic start;
      logic search;
      logic buf_reset;
   } mfch_cmd_s;
endpackage : mfch_pkg

// [tb/mfch_handler_assertions.sv]
// checker of the handler's host and link ports
// assumes binding to mfch_handler, watching ports only
`timescale 1ns/100ps
`default_nettype none
module mfch_handler_chk (
   // system
   input wire logic clock,
   input wire logic rstn,
   // host side
   input wire mfch_pkg::mfch_cmd_s cmd,
   input wire logic protocol_select_bit,
   input wire logic [1:0] interface_mode,
   input wire logic wr_valid,
   input wire logic rd_req,
   input wire logic rd_valid,
   input wire logic xfer_busy,
   input wire logic buf_empty,
   input wire logic buf_read_mode,
   input wire logic [7:0] active_channel_register,
   input wire logic active_channel_interrupt,
   // link side
   input wire logic link_clock,
   input wire logic port_line_oe
);
   import mfch_pkg::*;
   a_read_answer: assert property (@(posedge clock) disable iff (!rstn)
      rd_valid |-> $past(rd_req) && $past(buf_read_mode) && !$past(buf_empty))
      else $error("read answered without a taken request");
   a_write_fill: assert property (@(posedge clock) disable iff (!rstn)
      wr_valid && !xfer_busy && !buf_read_mode |=> !buf_empty)
      else $error("accepted write left buffer empty");
   a_start_busy: assert property (@(posedge clock) disable iff (!rstn)
      $rose(xfer_busy) |-> $past(cmd.start))
      else $error("transfer began without start");
   a_rx_after_tx: assert property (@(posedge clock) disable iff (!rstn)
      $rose(buf_read_mode) |-> $past(xfer_busy))
      else $error("read mode outside a transfer");
   a_irq_pulse: assert property (@(posedge clock) disable iff (!rstn)
      active_channel_interrupt |=> !active_channel_interrupt)
      else $error("interrupt longer than one cycle");
   a_irq_store: assert property (@(posedge clock) disable iff (!rstn)
      active_channel_interrupt |-> active_channel_register[7:6] == 2'h0
         && $past(active_channel_register[6]))
      else $error("interrupt without a running search");
   a_search_on: assert property (@(posedge clock) disable iff (!rstn)
      cmd.search && protocol_select_bit |=> active_channel_register[6])
      else $error("search did not start");
   a_search_off: assert property (@(posedge clock) disable iff (!rstn)
      cmd.search && !protocol_select_bit && !active_channel_register[6]
         |=> !active_channel_register[6])
      else $error("search started without handshake");
   a_oe_mode: assert property (@(posedge link_clock) disable iff (!rstn)
      port_line_oe |-> interface_mode == 2'h3)
      else $error("port line driven outside mode 3");
   c_found: cover property (@(posedge clock) disable iff (!rstn) active_channel_interrupt);
   c_read: cover property (@(posedge clock) disable iff (!rstn) rd_valid);
   c_done: cover property (@(posedge clock) disable iff (!rstn) $fell(xfer_busy));
endmodule : mfch_handler_chk
bind mfch_handler mfch_handler_chk chk_u (.clock, .rstn, .cmd, .protocol_select_bit,
   .interface_mode, .wr_valid, .rd_req, .rd_valid, .xfer_busy, .buf_empty, .buf_read_mode,
   .active_channel_register, .active_channel_interrupt, .link_clock, .port_line_oe);
`default_nettype wire

// [tb/mfch_handler_tb.sv]
// self-checking bench of the monitor/feature channel handler
// assumes mfch_subscriber on the link and the bound checker
`timescale 1ns/100ps
`default_nettype none
module mfch_handler_tb;
   import mfch_pkg::*;
   logic clock = 1'b0, link_clock = 1'b0, rstn = 1'b0;
   mfch_cmd_s cmd = '0;
   logic protocol_select_bit = 1'b0, wr_valid = 1'b0, rd_req = 1'b0;
   logic [1:0] interface_mode = 2'h0;
   logic [7:0] target_slot_register = 8'h12, mf_slot_map = 8'h30, wr_data = 8'h00;
   logic [7:0] rd_data, active_channel_register;
   logic rd_valid, xfer_busy, buf_empty, buf_read_mode, active_channel_interrupt;
   logic frame_sync, downstream_line, upstream_line, port_line_in, port_line_out, port_line_oe;
   int failures = 0, check_count = 0;
   always #25 clock = ~clock;
   always #24 link_clock = ~link_clock;
   mfch_handler dut_u (.clock, .rstn, .cmd, .protocol_select_bit, .interface_mode,
      .target_slot_register, .mf_slot_map, .wr_valid, .wr_data, .rd_req, .rd_data, .rd_valid,
      .xfer_busy, .buf_empty, .buf_read_mode, .active_channel_register,
      .active_channel_interrupt, .link_clock, .frame_sync, .downstream_line, .upstream_line,
      .port_line_in, .port_line_out, .port_line_oe);
   mfch_subscriber sub_u (.link_clock, .frame_sync, .downstream_line, .upstream_line,
      .port_line_out, .port_line_oe, .port_line_in);
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clock);
      #2;
   endtask : tick
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      check_count++;
      if (exp !== seen) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // holds wr_valid across the burst so it never drops and rises in one step
   task automatic wr(input logic [7:0] first, input int n);
      wr_valid = 1'b1;
      for (int i = 0; i < n; i++) begin
         wr_data = first + i[7:0];
         tick();
      end
      wr_valid = 1'b0;
   endtask : wr
   task automatic rd(input logic valid, input logic [7:0] exp);
      rd_req = 1'b1;
      tick();
      rd_req = 1'b0;
      chk("rd_valid", 8'(valid), 8'(rd_valid));
      if (valid) chk("rd_data", exp, rd_data);
      tick();
   endtask : rd
   task automatic xfer(input logic [1:0] code);
      cmd.code = code;
      cmd.start = 1'b1;
      tick();
      cmd.start = 1'b0;
      chk("xfer_busy", 8'h01, 8'(xfer_busy));
      for (int i = 0; i < 8000 && xfer_busy; i++) tick();
      chk("xfer_busy", 8'h00, 8'(xfer_busy));
      // busy drops early in the frame that still carries the last byte on the wire
      tick(300);
   endtask : xfer
   task automatic flush();
      cmd.buf_reset = 1'b1;
      tick();
      cmd.buf_reset = 1'b0;
      tick(8);
   endtask : flush
   task automatic seek(input logic exp_on);
      cmd.search = 1'b1;
      tick();
      cmd.search = 1'b0;
      chk("search_on", 8'(exp_on), 8'(active_channel_register[6]));
   endtask : seek
   task automatic complete_run();
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   // about thirty-two frames of traffic; five times that is a hang
   initial begin
      #2000000;
      failures++;
      complete_run();
   end
   initial begin
      tick(8);
      rstn = 1'b1;
      tick(2);
      chk("buf_empty", 8'h01, 8'(buf_empty));
      chk("port_line_oe", 8'h00, 8'(port_line_oe));
      rd(1'b0, 8'h00);
      wr(8'h10, 17);
      xfer(2'h1);
      chk("sent", 8'h10, 8'(sub_u.got.size()));
      for (int i = 0; i < 16; i++) chk("byte", 8'h10 + i[7:0], sub_u.got[i]);
      chk("stray", 8'h00, 8'(sub_u.stray));
      sub_u.got.delete();
      sub_u.resp = 8'hc3;
      wr(8'h3c, 1);
      xfer(2'h2);
      chk("buf_read_mode", 8'h01, 8'(buf_read_mode));
      rd(1'b1, 8'hc3);
      rd(1'b0, 8'h00);
      chk("sent", 8'h3c, sub_u.got[0]);
      flush();
      interface_mode = 2'h3;
      sub_u.mode3 = 1'b1;
      sub_u.got.delete();
      sub_u.resp = 8'h96;
      wr(8'h69, 1);
      xfer(2'h3);
      rd(1'b1, 8'h96);
      chk("sent", 8'h69, sub_u.got[0]);
      flush();
      interface_mode = 2'h0;
      sub_u.mode3 = 1'b0;
      seek(1'b0);
      protocol_select_bit = 1'b1;
      sub_u.hs = 1'b1;
      sub_u.tx_frames = 0;
      sub_u.got.delete();
      wr(8'ha5, 1);
      xfer(2'h1);
      chk("repeats", 8'h01, 8'(sub_u.got.size() >= 3));
      chk("byte", 8'ha5, sub_u.got[2]);
      sub_u.req_on = 1'b1;
      seek(1'b1);
      for (int i = 0; i < 2000 && !active_channel_interrupt; i++) tick();
      chk("irq", 8'h01, 8'(active_channel_interrupt));
      chk("active_channel", 8'h16, active_channel_register);
      complete_run();
   end
endmodule : mfch_handler_tb
`default_nettype wire

// [tb/mfch_subscriber.sv]
// subscriber side of the link: frame timing, answers and flags
// assumes the bench makes link_clock and sets the knobs by hierarchy
`timescale 1ns/100ps
`default_nettype none
module mfch_subscriber (
   // link
   input wire logic link_clock,
   output logic frame_sync,
   input wire logic downstream_line,
   output logic upstream_line,
   input wire logic port_line_out,
   input wire logic port_line_oe,
   output logic port_line_in
);
   logic [7:0] bit_n = 8'h00;
   logic [7:0] sr = 8'hff, resp = 8'hff, up_byte;
   logic [2:0] tgt = 3'h4, req_ch = 3'h5;
   logic mode3 = 1'b0, hs = 1'b0, req_on = 1'b0, heard = 1'b0, answer = 1'b0, ack = 1'b0;
   int tx_frames = 0, stray = 0;
   logic [7:0] got[$];
   wire [4:0] slot = bit_n[7:3];
   wire [2:0] ch = bit_n[7:5];
   wire [4:0] ans_slot = {tgt, 2'h2} + (mode3 ? 5'h04 : 5'h00);
   wire line = mode3 ? (port_line_oe ? port_line_out : 1'b1) : downstream_line;
   wire flag_tx_n = ~(req_on && ch == req_ch);
   wire flag_rx_n = ~(ack && ch == tgt);
   assign frame_sync = (bit_n == 8'h00);
   assign upstream_line = up_byte[~bit_n[2:0]];
   assign port_line_in = port_line_oe ? port_line_out : up_byte[~bit_n[2:0]];
   always @(posedge link_clock) bit_n <= bit_n + 8'h01;
   // slots nobody owns toggle every bit, so a stale level never passes
   always_comb begin
      up_byte = 8'h55;
      if (slot == ans_slot && (mode3 ? heard : answer)) up_byte = resp;
      else if (slot[1:0] == 2'h2) up_byte = 8'hff;
      else if (slot[1:0] == 2'h3) up_byte = {6'h3f, flag_rx_n, flag_tx_n};
   end
   always @(negedge link_clock) begin
      sr = {sr[6:0], line};
      if (bit_n[2:0] == 3'h7 && slot[1:0] == 2'h2 && sr != 8'hff) begin
         if (ch == tgt) begin
            got.push_back(sr);
            heard = 1'b1;
         end else begin
            stray++;
         end
      end
      if (bit_n[2:0] == 3'h7 && slot[1:0] == 2'h3 && ch == tgt) begin
         if (!sr[0]) tx_frames++;
         ack = hs && !sr[0] && tx_frames >= 3;
      end
      if (bit_n == 8'hff) begin
         answer = heard && !hs;
         heard = 1'b0;
      end
   end
endmodule : mfch_subscriber
`default_nettype wire
